// File: hw/ctw_defines.svh
// block map, field positions, command codes, frame and timing constants
// assumes a 25 MHz core clock; included by the tag block, the checker and the reader model
`ifndef CTW_DEFINES_SVH
`define CTW_DEFINES_SVH

// block addresses and storage index of the system word
`define CTW_BLK_OTP_LAST   8'h04
`define CTW_BLK_CNT_A      8'h05
`define CTW_BLK_CNT_R      8'h06
`define CTW_BLK_LOCK_FIRST 8'h07
`define CTW_BLK_LOCK_PAIR  8'h08
`define CTW_BLK_LOCK_LAST  8'h0F
`define CTW_BLK_USER_LAST  8'h7F
`define CTW_BLK_SYS        8'hFF
`define CTW_SYS_IDX        8'h80
`define CTW_NUM_WORDS      129

// fields of the counter and system words
`define CTW_RELOAD_HI      31
`define CTW_RELOAD_LO      21
`define CTW_LOCK_BASE      24
`define CTW_LOCK_OFS       5'h10

// delivery contents
`define CTW_CNT_A_INIT     32'hFFFFFFFE
`define CTW_CNT_R_INIT     32'hFFFFFFFF
`define CTW_ERASED         32'hFFFFFFFF
`define CTW_SYS_UPPER      24'hFFFFFF
`define CTW_ID_ERASED      8'hFF

// command codes and request lengths in bytes, check bytes included
`define CTW_CMD_READ       8'h08
`define CTW_CMD_WRITE      8'h09
`define CTW_CMD_UID        8'h0B
`define CTW_CMD_SELECT     8'h0E
`define CTW_LEN_READ       4'h4
`define CTW_LEN_WRITE      4'h8
`define CTW_LEN_UID        4'h3
`define CTW_LEN_SELECT     4'h4

// frame check
`define CTW_CRC_PRESET     16'hFFFF
`define CTW_CRC_POLY       16'h8408
`define CTW_CRC_RESIDUE    16'hF0B8

// buffers
`define CTW_RX_MAX         4'h8
`define CTW_TX_MAX         10

// link framing: start-of-frame and end-of-frame are 10 low then 2 high etu
`define CTW_SOF_LOW        4'hA
`define CTW_SOF_LAST       4'hB
`define CTW_CHR_LAST       4'h9
`define CTW_RX_DATA_LAST   3'h7
`define CTW_LFSR_SEED      8'h01

// timing
`define CTW_CLK_NS         40
`define CTW_ETU_NS         9440
`define CTW_ETU_CYCLES     (`CTW_ETU_NS / `CTW_CLK_NS)
`define CTW_PROG_US        5000
`define CTW_PROG_CYCLES    (`CTW_PROG_US * 1000 / `CTW_CLK_NS)
`define CTW_DRAIN_CYCLES   3'h4

`endif

// File: hw/ctw_pkg.sv
// state types for the tag write-policy block
// assumes nothing beyond the defines header
package ctw_pkg;

   typedef enum logic [2:0] {
      CORE_IDLE,
      CORE_DRAIN,
      CORE_EXEC,
      CORE_PROG,
      CORE_CRCG,
      CORE_TX
   } ctw_core_e;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_DATA,
      RX_STOP
   } ctw_rx_e;

   typedef enum logic [1:0] {
      SEG_SOF,
      SEG_CHR,
      SEG_EOF
   } ctw_seg_e;

endpackage : ctw_pkg

// File: hw/ctw_tag_block.sv
// contactless tag memory: block read, block write policy, selection
// assumes the front end delivers demodulated request bits on LINK_CLK_I,
// one bit per link edge, with RX_FRAME_I high across the data characters,
// and that RST_I follows field power-up
`timescale 1ns/1ps
`include "ctw_defines.svh"

module ctw_tag_block #(
   parameter int          PROG_CYCLES = `CTW_PROG_CYCLES,
   parameter bit          FIXED_ID_EN = 1'b0,
   // arbitrary value
   parameter logic [7:0]  FIXED_ID    = 8'h5A,
   // arbitrary value
   parameter logic [63:0] UID         = 64'h0123456789ABCDEF
) (
   // core clock and reset
   input  wire logic CLOCK_I,
   input  wire logic RST_I,
   // request link
   input  wire logic LINK_CLK_I,
   input  wire logic RX_BIT_I,
   input  wire logic RX_FRAME_I,
   // answer link
   output logic      TX_DATA_O,
   output logic      TX_ACTIVE_O,
   // status
   output logic      SELECTED_O,
   output logic      RELOAD_ARMED_O,
   output logic      BUSY_O
);

   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0]  d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) r = (r >> 1) ^ `CTW_CRC_POLY;
         else r = r >> 1;
      end
      return r;
   endfunction : crc_upd

   // ---------------- link domain: character receiver
   ctw_pkg::ctw_rx_e lk_st_r;
   logic [2:0]       lk_cnt_r;
   logic [7:0]       lk_sh_r;
   logic [8:0]       lk_hold_r;
   logic             lk_tog_r;

   always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         lk_st_r  <= ctw_pkg::RX_IDLE;
         lk_cnt_r <= 3'h0;
         lk_sh_r  <= 8'h00;
      end else begin
         case (lk_st_r)
            ctw_pkg::RX_IDLE: begin
               if (RX_FRAME_I && !RX_BIT_I) begin
                  lk_st_r  <= ctw_pkg::RX_DATA;
                  lk_cnt_r <= 3'h0;
               end
            end
            ctw_pkg::RX_DATA: begin
               lk_sh_r  <= {RX_BIT_I, lk_sh_r[7:1]};
               lk_cnt_r <= lk_cnt_r + 3'h1;
               if (lk_cnt_r == `CTW_RX_DATA_LAST) lk_st_r <= ctw_pkg::RX_STOP;
            end
            ctw_pkg::RX_STOP: lk_st_r <= ctw_pkg::RX_IDLE;
            default: lk_st_r <= ctw_pkg::RX_IDLE;
         endcase
      end
   end

   // byte plus stop-bit error held stable for ten link edges per toggle
   always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         lk_hold_r <= 9'h000;
         lk_tog_r  <= 1'b0;
      end else if (lk_st_r == ctw_pkg::RX_STOP) begin
         lk_hold_r <= {!RX_BIT_I, lk_sh_r};
         lk_tog_r  <= !lk_tog_r;
      end
   end

   // ---------------- crossings into the core domain
   logic tog_s1_r, tog_s2_r, tog_s3_r;
   logic frm_s1_r, frm_s2_r, frm_s3_r;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
         frm_s1_r <= 1'b0;
         frm_s2_r <= 1'b0;
         frm_s3_r <= 1'b0;
      end else begin
         tog_s1_r <= lk_tog_r;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         frm_s1_r <= RX_FRAME_I;
         frm_s2_r <= frm_s1_r;
         frm_s3_r <= frm_s2_r;
      end
   end

   wire byte_ev  = tog_s2_r ^ tog_s3_r;
   wire frm_rise = frm_s2_r & !frm_s3_r;
   wire frm_fall = !frm_s2_r & frm_s3_r;

   // ---------------- core state
   ctw_pkg::ctw_core_e st_r;
   ctw_pkg::ctw_seg_e  seg_r;
   logic [31:0] mem_r [0:`CTW_NUM_WORDS-1];
   logic [7:0]  rx_buf_r [0:7];
   logic [3:0]  rx_cnt_r;
   logic [15:0] rx_crc_r;
   logic        rx_err_r;
   logic        rx_open_r;
   logic [7:0]  tx_byte_r [0:`CTW_TX_MAX-1];
   logic [3:0]  tx_len_r;
   logic [3:0]  tx_idx_r;
   logic [15:0] tx_crc_r;
   logic [2:0]  drain_r;
   logic [31:0] prog_cnt_r;
   logic [7:0]  wr_idx_r;
   logic [31:0] wr_val_r;
   logic        wr_rel_r;
   logic        selected_r;
   logic        reload_r;
   logic [7:0]  lfsr_r;
   logic [7:0]  id_r;
   logic        id_cap_r;
   logic [7:0]  etu_cnt_r;
   logic [3:0]  tx_bit_r;
   logic [3:0]  tx_chr_r;

   // ---------------- request decode and write policy
   logic [7:0]  cmd, addr, idx, sel_id;
   logic [31:0] wdata, old, new_val;
   logic        addr_ok, frame_ok, lock_bit, wr_ok, new_rel;

   always_comb begin
      cmd      = rx_buf_r[0];
      addr     = rx_buf_r[1];
      wdata    = {rx_buf_r[5], rx_buf_r[4], rx_buf_r[3], rx_buf_r[2]};
      idx      = (addr == `CTW_BLK_SYS) ? `CTW_SYS_IDX : {1'b0, addr[6:0]};
      addr_ok  = (addr <= `CTW_BLK_USER_LAST) || (addr == `CTW_BLK_SYS);
      old      = mem_r[idx];
      sel_id   = FIXED_ID_EN ? mem_r[`CTW_SYS_IDX][7:0] : id_r;
      frame_ok = (rx_crc_r == `CTW_CRC_RESIDUE) && !rx_err_r;
      if (addr <= `CTW_BLK_LOCK_PAIR)
         lock_bit = mem_r[`CTW_SYS_IDX][`CTW_LOCK_BASE];
      else
         lock_bit = mem_r[`CTW_SYS_IDX][5'(addr[3:0]) + `CTW_LOCK_OFS];
      new_rel = 1'b0;
      if (addr <= `CTW_BLK_OTP_LAST) begin
         new_val = reload_r ? wdata : (old & wdata);
         wr_ok   = reload_r || (old != 32'h00000000);
      end else if (addr <= `CTW_BLK_CNT_R) begin
         new_val = wdata;
         wr_ok   = wdata < old;
         new_rel = (addr == `CTW_BLK_CNT_R) &&
                   (wdata[`CTW_RELOAD_HI:`CTW_RELOAD_LO] !=
                    old[`CTW_RELOAD_HI:`CTW_RELOAD_LO]);
      end else if (addr <= `CTW_BLK_USER_LAST) begin
         new_val = wdata;
         wr_ok   = !((addr <= `CTW_BLK_LOCK_LAST) && !lock_bit);
      end else begin
         new_val = old & wdata;
         wr_ok   = old != 32'h00000000;
      end
   end

   wire in_exec  = (st_r == ctw_pkg::CORE_EXEC) && frame_ok;
   wire sel_hit  = addr == sel_id;
   wire do_sel   = in_exec && (rx_cnt_r == `CTW_LEN_SELECT) &&
                   (cmd == `CTW_CMD_SELECT);
   wire do_read  = in_exec && selected_r && addr_ok &&
                   (rx_cnt_r == `CTW_LEN_READ) && (cmd == `CTW_CMD_READ);
   wire do_uid   = in_exec && selected_r &&
                   (rx_cnt_r == `CTW_LEN_UID) && (cmd == `CTW_CMD_UID);
   wire do_write = in_exec && selected_r && addr_ok && wr_ok &&
                   (rx_cnt_r == `CTW_LEN_WRITE) && (cmd == `CTW_CMD_WRITE);
   wire reply    = (do_sel && sel_hit) || do_read || do_uid;
   wire commit   = (st_r == ctw_pkg::CORE_PROG) &&
                   (prog_cnt_r == 32'(PROG_CYCLES - 1));
   wire crc_done = (st_r == ctw_pkg::CORE_CRCG) && (tx_idx_r == tx_len_r);
   wire etu_tick = etu_cnt_r == 8'(`CTW_ETU_CYCLES - 1);
   wire tx_done  = (st_r == ctw_pkg::CORE_TX) && etu_tick &&
                   (seg_r == ctw_pkg::SEG_EOF) && (tx_bit_r == `CTW_SOF_LAST);

   // ---------------- main sequence
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         st_r    <= ctw_pkg::CORE_IDLE;
         drain_r <= 3'h0;
      end else begin
         case (st_r)
            ctw_pkg::CORE_IDLE: begin
               if (frm_fall && rx_open_r) begin
                  st_r    <= ctw_pkg::CORE_DRAIN;
                  drain_r <= 3'h0;
               end
            end
            // lets a last byte that crossed slower than the frame land
            ctw_pkg::CORE_DRAIN: begin
               drain_r <= drain_r + 3'h1;
               if (drain_r == `CTW_DRAIN_CYCLES) st_r <= ctw_pkg::CORE_EXEC;
            end
            ctw_pkg::CORE_EXEC: begin
               if (reply) st_r <= ctw_pkg::CORE_CRCG;
               else if (do_write) st_r <= ctw_pkg::CORE_PROG;
               else st_r <= ctw_pkg::CORE_IDLE;
            end
            ctw_pkg::CORE_PROG: if (commit) st_r <= ctw_pkg::CORE_IDLE;
            ctw_pkg::CORE_CRCG: if (crc_done) st_r <= ctw_pkg::CORE_TX;
            ctw_pkg::CORE_TX:   if (tx_done) st_r <= ctw_pkg::CORE_IDLE;
            default: st_r <= ctw_pkg::CORE_IDLE;
         endcase
      end
   end

   // ---------------- request assembly, only while idle or draining
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         rx_cnt_r  <= 4'h0;
         rx_crc_r  <= `CTW_CRC_PRESET;
         rx_err_r  <= 1'b0;
         rx_open_r <= 1'b0;
         for (int i = 0; i < 8; i++) rx_buf_r[i] <= 8'h00;
      end else if (st_r == ctw_pkg::CORE_IDLE && frm_rise) begin
         rx_cnt_r  <= 4'h0;
         rx_crc_r  <= `CTW_CRC_PRESET;
         rx_err_r  <= 1'b0;
         rx_open_r <= 1'b1;
      end else if ((st_r == ctw_pkg::CORE_IDLE ||
                    st_r == ctw_pkg::CORE_DRAIN) && rx_open_r && byte_ev) begin
         // residue over data and check bytes replaces a separate compare
         rx_crc_r <= crc_upd(rx_crc_r, lk_hold_r[7:0]);
         rx_err_r <= rx_err_r | lk_hold_r[8] | (rx_cnt_r == `CTW_RX_MAX);
         if (rx_cnt_r != `CTW_RX_MAX) begin
            rx_buf_r[rx_cnt_r[2:0]] <= lk_hold_r[7:0];
            rx_cnt_r <= rx_cnt_r + 4'h1;
         end
      end else if (st_r == ctw_pkg::CORE_EXEC) begin
         rx_open_r <= 1'b0;
      end
   end

   // ---------------- self-timed programming; commit happens in one edge
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         prog_cnt_r <= 32'h00000000;
         wr_idx_r   <= 8'h00;
         wr_val_r   <= 32'h00000000;
         wr_rel_r   <= 1'b0;
      end else if (do_write) begin
         prog_cnt_r <= 32'h00000000;
         wr_idx_r   <= idx;
         wr_val_r   <= new_val;
         wr_rel_r   <= new_rel;
      end else if (st_r == ctw_pkg::CORE_PROG) begin
         prog_cnt_r <= prog_cnt_r + 32'h00000001;
      end
   end

   // storage; a reset during programming drops the pending word whole
   genvar g;
   generate
      for (g = 0; g < `CTW_NUM_WORDS; g++) begin : g_word
         localparam logic [31:0] INIT =
            (g == 5)   ? `CTW_CNT_A_INIT :
            (g == 6)   ? `CTW_CNT_R_INIT :
            (g == 128) ? {`CTW_SYS_UPPER,
                          FIXED_ID_EN ? FIXED_ID : `CTW_ID_ERASED} :
                         `CTW_ERASED;
         always_ff @(posedge CLOCK_I or posedge RST_I) begin
            if (RST_I) mem_r[g] <= INIT;
            else if (commit && wr_idx_r == 8'(g)) mem_r[g] <= wr_val_r;
         end
      end
   endgenerate

   // ---------------- selection and reload mode
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         selected_r <= 1'b0;
         reload_r   <= 1'b0;
      end else if (do_sel) begin
         selected_r <= sel_hit;
         reload_r   <= 1'b0;
      end else if (commit && wr_rel_r) begin
         reload_r   <= 1'b1;
      end
   end

   // random id taken at the first frame, whose arrival time is unpredictable
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         lfsr_r   <= `CTW_LFSR_SEED;
         id_r     <= 8'h00;
         id_cap_r <= 1'b0;
      end else begin
         lfsr_r <= {lfsr_r[6:0],
                    lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         if (frm_rise && !id_cap_r && !FIXED_ID_EN) begin
            id_r     <= lfsr_r;
            id_cap_r <= 1'b1;
         end
      end
   end

   // ---------------- answer payload and check bytes
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         tx_len_r <= 4'h0;
         tx_idx_r <= 4'h0;
         tx_crc_r <= `CTW_CRC_PRESET;
         for (int i = 0; i < `CTW_TX_MAX; i++) tx_byte_r[i] <= 8'h00;
      end else if (st_r == ctw_pkg::CORE_EXEC) begin
         tx_idx_r <= 4'h0;
         tx_crc_r <= `CTW_CRC_PRESET;
         if (do_uid) begin
            tx_len_r <= 4'h8;
            for (int i = 0; i < 8; i++) tx_byte_r[i] <= UID[8*i +: 8];
         end else if (do_read) begin
            tx_len_r <= 4'h4;
            for (int i = 0; i < 4; i++) tx_byte_r[i] <= old[8*i +: 8];
         end else begin
            tx_len_r     <= 4'h1;
            tx_byte_r[0] <= sel_id;
         end
      end else if (st_r == ctw_pkg::CORE_CRCG) begin
         if (!crc_done) begin
            tx_crc_r <= crc_upd(tx_crc_r, tx_byte_r[tx_idx_r]);
            tx_idx_r <= tx_idx_r + 4'h1;
         end else begin
            tx_byte_r[tx_len_r]        <= ~tx_crc_r[7:0];
            tx_byte_r[tx_len_r + 4'h1] <= ~tx_crc_r[15:8];
            tx_len_r                   <= tx_len_r + 4'h2;
         end
      end
   end

   // ---------------- answer serialiser, one bit per etu
   logic tx_bit;

   always_comb begin
      case (seg_r)
         ctw_pkg::SEG_CHR: begin
            if (tx_bit_r == 4'h0) tx_bit = 1'b0;
            else if (tx_bit_r == `CTW_CHR_LAST) tx_bit = 1'b1;
            else tx_bit = tx_byte_r[tx_chr_r][3'(tx_bit_r - 4'h1)];
         end
         default: tx_bit = tx_bit_r >= `CTW_SOF_LOW;
      endcase
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         etu_cnt_r <= 8'h00;
         seg_r     <= ctw_pkg::SEG_SOF;
         tx_bit_r  <= 4'h0;
         tx_chr_r  <= 4'h0;
      end else if (st_r != ctw_pkg::CORE_TX) begin
         etu_cnt_r <= 8'h00;
         seg_r     <= ctw_pkg::SEG_SOF;
         tx_bit_r  <= 4'h0;
         tx_chr_r  <= 4'h0;
      end else begin
         etu_cnt_r <= etu_tick ? 8'h00 : etu_cnt_r + 8'h01;
         if (etu_tick) begin
            tx_bit_r <= tx_bit_r + 4'h1;
            case (seg_r)
               ctw_pkg::SEG_SOF: begin
                  if (tx_bit_r == `CTW_SOF_LAST) begin
                     seg_r    <= ctw_pkg::SEG_CHR;
                     tx_bit_r <= 4'h0;
                  end
               end
               ctw_pkg::SEG_CHR: begin
                  if (tx_bit_r == `CTW_CHR_LAST) begin
                     tx_bit_r <= 4'h0;
                     tx_chr_r <= tx_chr_r + 4'h1;
                     if (tx_chr_r == tx_len_r - 4'h1)
                        seg_r <= ctw_pkg::SEG_EOF;
                  end
               end
               ctw_pkg::SEG_EOF: ;
               default: seg_r <= ctw_pkg::SEG_SOF;
            endcase
         end
      end
   end

   // ---------------- registered outputs
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         TX_DATA_O      <= 1'b1;
         TX_ACTIVE_O    <= 1'b0;
         SELECTED_O     <= 1'b0;
         RELOAD_ARMED_O <= 1'b0;
         BUSY_O         <= 1'b0;
      end else begin
         TX_DATA_O      <= (st_r == ctw_pkg::CORE_TX) ? tx_bit : 1'b1;
         TX_ACTIVE_O    <= st_r == ctw_pkg::CORE_TX;
         SELECTED_O     <= selected_r;
         RELOAD_ARMED_O <= reload_r;
         BUSY_O         <= st_r != ctw_pkg::CORE_IDLE;
      end
   end

endmodule : ctw_tag_block

// File: tb/ctw_tag_block_properties.sv
// checker for the tag block answer link and status flags
// assumes the core clock domain only; bound to every ctw_tag_block
`timescale 1ns/1ps
`include "ctw_defines.svh"

module ctw_tag_block_properties (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // watched outputs
   input wire logic TX_DATA_O,
   input wire logic TX_ACTIVE_O,
   input wire logic SELECTED_O,
   input wire logic RELOAD_ARMED_O,
   input wire logic BUSY_O
);
   logic [8:0] etu_r;

   // phase inside the current answer bit, zero at each bit boundary
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I)
         etu_r <= 9'h000;
      else if (!TX_ACTIVE_O || etu_r == 9'(`CTW_ETU_CYCLES - 1))
         etu_r <= 9'h000;
      else
         etu_r <= etu_r + 9'h001;
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   sequence sof_low;
      !TX_DATA_O [*8];
   endsequence

   sequence eof_tail;
      $past(TX_DATA_O) && !$past(TX_DATA_O, 600);
   endsequence

   a_reply_needs_select: assert property (
      $rose(TX_ACTIVE_O) |-> SELECTED_O)
      else $error("answer started while not selected");
   a_sof_starts_low: assert property (
      $rose(TX_ACTIVE_O) |-> sof_low)
      else $error("answer start of frame not low");
   a_eof_ends_high: assert property ($fell(TX_ACTIVE_O) |-> eof_tail)
      else $error("answer end of frame malformed");
   a_idle_line_high: assert property (!TX_ACTIVE_O |-> TX_DATA_O)
      else $error("answer line not high when idle");
   a_bit_stands: assert property (TX_ACTIVE_O && $past(TX_ACTIVE_O)
      && $changed(TX_DATA_O) |-> etu_r == 9'h000)
      else $error("answer bit changed inside a bit time");
   a_tx_inside_busy: assert property (TX_ACTIVE_O |-> BUSY_O)
      else $error("answer sent while core idle");
   a_select_in_exec: assert property (
      $changed(SELECTED_O) |-> $past(BUSY_O))
      else $error("selection changed without a request");
   a_reload_in_exec: assert property (
      $changed(RELOAD_ARMED_O) |-> $past(BUSY_O))
      else $error("reload mode changed without a request");
   a_arm_needs_sel: assert property (
      $rose(RELOAD_ARMED_O) |-> SELECTED_O)
      else $error("reload mode armed while not selected");
   a_select_clears: assert property (
      $rose(SELECTED_O) |-> !RELOAD_ARMED_O)
      else $error("reload mode survived a selection");
   a_reset_clean: assert property ($fell(RST_I) |-> !SELECTED_O
      && !RELOAD_ARMED_O && !BUSY_O)
      else $error("state not cleared by power-up");
endmodule : ctw_tag_block_properties

bind ctw_tag_block ctw_tag_block_properties u_props (
   .CLOCK_I(CLOCK_I), .RST_I(RST_I), .TX_DATA_O(TX_DATA_O),
   .TX_ACTIVE_O(TX_ACTIVE_O), .SELECTED_O(SELECTED_O),
   .RELOAD_ARMED_O(RELOAD_ARMED_O), .BUSY_O(BUSY_O));

// File: tb/ctw_reader_model.sv
// reader model: sends request frames, decodes answer frames
// assumes the core clock for answer sampling; link clock runs in frames only
`timescale 1ns/1ps
`include "ctw_defines.svh"

module ctw_reader_model (
   // answer side
   input  wire logic clk_i,
   input  wire logic tx_data_i,
   input  wire logic tx_active_i,
   // request side
   output logic      link_clk_o,
   output logic      rx_bit_o,
   output logic      rx_frame_o
);
   localparam int ETU = `CTW_ETU_CYCLES;
   logic       run = 1'b1;
   logic       good;
   logic [7:0] rx[$];

   initial begin
      link_clk_o = 1'b0;
      rx_bit_o = 1'b0;
      rx_frame_o = 1'b0;
      #7;
      forever begin
         #15;
         if (run) link_clk_o = ~link_clk_o;
      end
   end

   function automatic logic [15:0] crc(input logic [7:0] q[$]);
      logic [15:0] c = 16'hFFFF;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return ~c;
   endfunction : crc

   // stop the link clock low so nothing clocks between frames
   task automatic idle;
      @(negedge link_clk_o);
      run = 1'b0;
   endtask : idle

   task automatic send(input logic [7:0] q[$], input bit bad);
      logic [15:0] c;
      logic [9:0]  ch;
      c = crc(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      run = 1'b1;
      @(posedge link_clk_o);
      rx_frame_o <= 1'b1;
      rx_bit_o <= 1'b1;
      foreach (q[i]) begin
         ch = {1'b1, q[i], 1'b0};
         for (int k = 0; k < 10; k++) begin
            @(posedge link_clk_o);
            rx_bit_o <= ch[k];
         end
      end
      @(posedge link_clk_o);
      rx_frame_o <= 1'b0;
      rx_bit_o <= 1'b0;
      repeat (2) @(posedge link_clk_o);
      idle();
   endtask : send

   task automatic mark;
      for (int k = 0; k < 12; k++) begin
         if (tx_data_i !== (k >= 10)) good = 1'b0;
         repeat (ETU) @(negedge clk_i);
      end
   endtask : mark

   task automatic recv(input int n);
      logic [9:0] ch;
      int         t = 0;
      rx = {};
      while (!tx_active_i && t < 400) begin
         @(negedge clk_i);
         t++;
      end
      good = tx_active_i;
      repeat (ETU / 2) @(negedge clk_i);
      mark();
      for (int i = 0; i < n + 2; i++) begin
         for (int k = 0; k < 10; k++) begin
            ch[k] = tx_data_i;
            repeat (ETU) @(negedge clk_i);
         end
         if (ch[0] !== 1'b0 || ch[9] !== 1'b1) good = 1'b0;
         rx.push_back(ch[8:1]);
      end
      mark();
      if (crc(rx[0:n-1]) !== {rx[n+1], rx[n]}) good = 1'b0;
   endtask : recv
endmodule : ctw_reader_model

// File: tb/ctw_tag_block_test.sv
// self-checking bench for the tag write-policy block
// assumes the reader model and the checker bound to the design
`timescale 1ns/1ps

module ctw_tag_block_test;
   localparam int PROG_C = 20;
   // arbitrary value
   localparam logic [7:0] FID = 8'h3C;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire logic lclk, rx_bit, rx_frame, tx_data, tx_act, seld, rld, busy;
   int n_errors = 0;
   int n_tests = 0;

   always #20 clk = ~clk;

   ctw_tag_block #(.PROG_CYCLES(PROG_C), .FIXED_ID_EN(1'b1), .FIXED_ID(FID))
   dut (.CLOCK_I(clk), .RST_I(rst), .LINK_CLK_I(lclk), .RX_BIT_I(rx_bit),
        .RX_FRAME_I(rx_frame), .TX_DATA_O(tx_data), .TX_ACTIVE_O(tx_act),
        .SELECTED_O(seld), .RELOAD_ARMED_O(rld), .BUSY_O(busy));

   ctw_reader_model rdr (.clk_i(clk), .tx_data_i(tx_data),
      .tx_active_i(tx_act), .link_clk_o(lclk), .rx_bit_o(rx_bit),
      .rx_frame_o(rx_frame));

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // busy length tells an accepted write from a refused one
   task automatic xfer(input logic [7:0] q[$], input int nr, input bit bad,
                       output int bl);
      int t = 0;
      bit tx = 1'b0;
      bl = 0;
      repeat (4) @(negedge clk);
      rdr.send(q, bad);
      if (nr > 0) rdr.recv(nr);
      if (nr > 0) chk("reply frame", 1, rdr.good);
      while (!busy && t < 40) begin
         @(negedge clk);
         t++;
      end
      while (busy && bl < 4000) begin
         @(negedge clk);
         tx |= tx_act;
         bl++;
      end
      if (nr == 0) chk("silent", 0, tx);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit ok);
      int bl;
      xfer({8'h09, a, d[7:0], d[15:8], d[23:16], d[31:24]}, 0, 0, bl);
      chk("write accepted", ok, bl > PROG_C);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      int bl;
      xfer({8'h08, a}, 4, 0, bl);
      chk("read word", e, {rdr.rx[3], rdr.rx[2], rdr.rx[1], rdr.rx[0]});
   endtask : rd

   task automatic t_unselected;
      int bl;
      xfer({8'h08, 8'h00}, 0, 0, bl);
      xfer({8'h09, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 0, bl);
      xfer({8'h0B}, 0, 0, bl);
      xfer({8'h0E, FID}, 0, 1, bl);
      xfer({8'h55, FID}, 0, 0, bl);
      chk("selected", 0, seld);
   endtask : t_unselected

   task automatic t_select;
      int bl;
      xfer({8'h0E, FID}, 1, 0, bl);
      chk("selection id", FID, rdr.rx[0]);
      chk("selected", 1, seld);
   endtask : t_select

   task automatic t_one_time;
      wr(8'h00, 32'hF0F0F0F0, 1);
      wr(8'h00, 32'h3C3C3C3C, 1);
      wr(8'h01, 32'h00000000, 1);
      wr(8'h01, 32'hFFFFFFFF, 0);
      rd(8'h00, 32'h30303030);
   endtask : t_one_time

   task automatic t_counters;
      int bl;
      wr(8'h05, 32'hFFFFFFFE, 0);
      wr(8'h05, 32'h00000001, 1);
      wr(8'h05, 32'h00000000, 1);
      wr(8'h05, 32'h00000000, 0);
      wr(8'h06, 32'hFFFFFFFF, 0);
      wr(8'h06, 32'hFFFFFFF0, 1);
      chk("reload armed", 0, rld);
      wr(8'h06, 32'hFFDFFFF0, 1);
      chk("reload armed", 1, rld);
      wr(8'h01, 32'hFFFFFFFF, 1);
      wr(8'h00, 32'h12345678, 1);
      rd(8'h00, 32'h12345678);
      xfer({8'h0E, FID}, 1, 0, bl);
      chk("reload armed", 0, rld);
   endtask : t_counters

   task automatic t_lock;
      wr(8'h07, 32'h11111111, 1);
      wr(8'hFF, 32'hFEFFFFFF, 1);
      wr(8'h07, 32'h22222222, 0);
      wr(8'h08, 32'h22222222, 0);
      wr(8'h09, 32'h22222222, 1);
      wr(8'h7F, 32'h22222222, 1);
      wr(8'h80, 32'h22222222, 0);
      rd(8'h07, 32'h11111111);
      wr(8'hFF, 32'h00000000, 1);
      wr(8'hFF, 32'hFFFFFFFF, 0);
   endtask : t_lock

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdr.idle();
      repeat (8) @(posedge clk);
      t_unselected();
      t_select();
      t_one_time();
      t_counters();
      t_lock();
      end_sim();
   end

   initial begin
      // three reads and two selects take about 85k cycles of answer time
      repeat (98000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule : ctw_tag_block_test
